// ### absolute_home_offset_store.sv
// home offset store: register words, homing capture, position correction
//
// Notes on behaviour
// R1 - absolute homing stores offset so position reads zero
// R2 - high word is upper 32 bits of multi-turn
// R3 - scale offset built from upper and lower 24 bits
// R4 - offsets ignored when encoder mode is incremental
// R5 - after homing only offset words saved to memory
// R6 - master resets home by writing zeros, then saving
// R7 - manual writes apply only after power cycle
// R8 - master should not write offset words by hand
// R9 - only zero is a supported manual value
// R10 - low word holds lower 32 bits, signed, rw
`timescale 1ns/1ns
module absolute_home_offset_store
   import home_offset_pkg::*;
(
   input  wire logic                                  clk_sys,
   input  wire logic                                  rst,
   // register port
   input  wire logic [home_offset_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [home_offset_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                                  reg_wr,
   input  wire logic                                  reg_rd,
   output      logic [home_offset_pkg::DATA_W-1:0]    reg_rdata,
   // homing and position source
   input  wire logic                                  homing_done,
   input  wire logic                                  scale_sel,
   input  wire logic [home_offset_pkg::POS_W-1:0]     home_raw,
   input  wire logic [home_offset_pkg::SCALE_PART_W-1:0] scale_upper,
   input  wire logic [home_offset_pkg::SCALE_PART_W-1:0] scale_lower,
   input  wire logic [home_offset_pkg::POS_W-1:0]     pos_raw,
   // image restored from nonvolatile memory at power-up
   input  wire logic                                  boot_valid,
   input  wire logic [home_offset_pkg::DATA_W-1:0]    boot_high,
   input  wire logic [home_offset_pkg::DATA_W-1:0]    boot_low,
   // nonvolatile memory write port
   output      logic                                  nvm_wr_req,
   output      logic [home_offset_pkg::ADDR_W-1:0]    nvm_wr_addr,
   output      logic [home_offset_pkg::DATA_W-1:0]    nvm_wr_data,
   input  wire logic                                  nvm_wr_ack,
   // corrected position
   output      logic [home_offset_pkg::POS_W-1:0]     act_pos,
   output      logic                                  offset_applied,
   output      logic                                  save_busy
);
   import home_offset_pkg::*;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------

   function automatic logic is_incremental(input logic [7:0] mode);
      return mode == ENC_MODE_INCR;
   endfunction : is_incremental

   function automatic logic [POS_W-1:0] scale_offset(
      input logic [SCALE_PART_W-1:0] upper,
      input logic [SCALE_PART_W-1:0] lower
   );
      logic [2*SCALE_PART_W-1:0] joined;
      joined = {upper, lower};
      // sign extend the 48 bit scale count to 64 bits
      return {{(POS_W-2*SCALE_PART_W){joined[2*SCALE_PART_W-1]}}, joined};
   endfunction : scale_offset

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------

   logic signed [31:0] ofs_high_q, ofs_high_d;
   logic signed [31:0] ofs_low_q, ofs_low_d;
   logic [POS_W-1:0]   active_q, active_d;
   logic [7:0]         enc_mode_q, enc_mode_d;
   logic               nonzero_q, nonzero_d;
   logic               homed_q, homed_d;
   logic               save_start_q, save_start_d;
   logic [31:0]        rdata_q, rdata_d;
   logic [POS_W-1:0]   act_pos_q, act_pos_d;
   logic               applied_q, applied_d;

   logic [POS_W-1:0]   home_ofs;
   logic               wr_high;
   logic               wr_low;
   logic               wr_ctrl;
   logic               wr_mode;
   logic               incr;
   logic               home_update;
   logic               pending;

   offset_save_if save_link();

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------

   always_comb begin
      wr_high = 1'b0;
      wr_low  = 1'b0;
      wr_ctrl = 1'b0;
      wr_mode = 1'b0;
      if (reg_wr) begin
         if (reg_addr == OFS_HIGH_ADDR) begin
            wr_high = 1'b1;
         end else if (reg_addr == OFS_LOW_ADDR) begin
            wr_low = 1'b1;
         end else if (reg_addr == CTRL_ADDR) begin
            wr_ctrl = 1'b1;
         end else if (reg_addr == ENC_MODE_ADDR) begin
            wr_mode = 1'b1;
         end
      end
   end

   assign incr = is_incremental(enc_mode_q);

   // offset that makes the corrected position zero at the home point
   assign home_ofs = scale_sel ? scale_offset(scale_upper, scale_lower) // R3
                               : home_raw;                              // R2

   // automatic capture only in absolute mode
   assign home_update = homing_done && !incr; // R1 R4

   assign pending = (active_q != {ofs_high_q, ofs_low_q});

   // ------------------------------------------------------------------
   // offset words and settings
   // ------------------------------------------------------------------

   always_comb begin
      ofs_high_d   = ofs_high_q;
      ofs_low_d    = ofs_low_q;
      active_d     = active_q;
      enc_mode_d   = enc_mode_q;
      nonzero_d    = nonzero_q;
      homed_d      = homed_q;
      save_start_d = 1'b0;
      if (wr_mode) begin
         enc_mode_d = reg_wdata[ENC_MODE_W-1:0];
      end
      // manual writes only change the stored word R7 R10
      if (wr_high) begin
         ofs_high_d = reg_wdata;
      end
      if (wr_low) begin
         ofs_low_d = reg_wdata;
      end
      // flag unsupported manual values R9
      if ((wr_high || wr_low) && reg_wdata != OFS_RESET) begin
         nonzero_d = 1'b1;
      end
      // master commit of the stored words R6
      if (wr_ctrl && reg_wdata[CTRL_SAVE_BIT]) begin
         save_start_d = 1'b1;
      end
      // a homing capture wins over a same-cycle manual write
      if (home_update) begin
         ofs_high_d   = home_ofs[POS_W-1:DATA_W];      // R2
         ofs_low_d    = home_ofs[DATA_W-1:0];          // R10
         active_d     = home_ofs;                      // R1
         nonzero_d    = 1'b0;
         homed_d      = 1'b1;
         save_start_d = 1'b1;                          // R5
      end
      // power-up image loads both stored and active words R7
      if (boot_valid) begin
         ofs_high_d = boot_high;
         ofs_low_d  = boot_low;
         active_d   = {boot_high, boot_low};
         nonzero_d  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ofs_high_q   <= OFS_RESET;
         ofs_low_q    <= OFS_RESET;
         active_q     <= {OFS_RESET, OFS_RESET};
         enc_mode_q   <= ENC_MODE_RESET;
         nonzero_q    <= 1'b0;
         homed_q      <= 1'b0;
         save_start_q <= 1'b0;
      end else begin
         ofs_high_q   <= ofs_high_d;
         ofs_low_q    <= ofs_low_d;
         active_q     <= active_d;
         enc_mode_q   <= enc_mode_d;
         nonzero_q    <= nonzero_d;
         homed_q      <= homed_d;
         save_start_q <= save_start_d;
      end
   end

   // ------------------------------------------------------------------
   // nonvolatile save
   // ------------------------------------------------------------------

   assign save_link.start     = save_start_q;
   assign save_link.high_word = ofs_high_q;
   assign save_link.low_word  = ofs_low_q;

   offset_nvm_writer u_writer (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .save        (save_link.writer),
      .nvm_wr_req  (nvm_wr_req),
      .nvm_wr_addr (nvm_wr_addr),
      .nvm_wr_data (nvm_wr_data),
      .nvm_wr_ack  (nvm_wr_ack)
   );

   assign save_busy = save_link.busy;

   // ------------------------------------------------------------------
   // position correction
   // ------------------------------------------------------------------

   always_comb begin
      // incremental mode passes the raw count untouched R4
      applied_d = !incr;
      act_pos_d = incr ? pos_raw : pos_raw - active_q; // R1
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         act_pos_q <= {POS_W{1'b0}};
         applied_q <= 1'b0;
      end else begin
         act_pos_q <= act_pos_d;
         applied_q <= applied_d;
      end
   end

   assign act_pos        = act_pos_q;
   assign offset_applied = applied_q;

   // ------------------------------------------------------------------
   // read back
   // ------------------------------------------------------------------

   always_comb begin
      rdata_d = RDATA_UNMAPPED;
      if (reg_rd) begin
         if (reg_addr == OFS_HIGH_ADDR) begin
            rdata_d = ofs_high_q; // R10
         end else if (reg_addr == OFS_LOW_ADDR) begin
            rdata_d = ofs_low_q; // R10
         end else if (reg_addr == ENC_MODE_ADDR) begin
            rdata_d = {{(DATA_W-ENC_MODE_W){1'b0}}, enc_mode_q};
         end else if (reg_addr == STATUS_ADDR) begin
            rdata_d[ST_APPLIED_BIT] = applied_q;
            rdata_d[ST_BUSY_BIT]    = save_link.busy;
            rdata_d[ST_NONZERO_BIT] = nonzero_q;
            rdata_d[ST_PENDING_BIT] = pending;
            rdata_d[ST_HOMED_BIT]   = homed_q;
            rdata_d[ST_SCALE_BIT]   = scale_sel;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_q <= RDATA_UNMAPPED;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : absolute_home_offset_store

// ### absolute_home_offset_store_sva.sv
// assertions on the home offset store ports
`timescale 1ns/1ns
module absolute_home_offset_store_sva (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic        homing_done,
   input wire logic        boot_valid,
   input wire logic        scale_sel,
   input wire logic [63:0] home_raw,
   input wire logic [63:0] pos_raw,
   input wire logic        nvm_wr_req,
   input wire logic [15:0] nvm_wr_addr,
   input wire logic [31:0] nvm_wr_data,
   input wire logic        nvm_wr_ack,
   input wire logic [63:0] act_pos,
   input wire logic        offset_applied
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   property p_rd_zero;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data outside read cycle");
   property p_home_req;
      homing_done && offset_applied && !nvm_wr_req && !boot_valid
         |-> ##2 nvm_wr_req && nvm_wr_addr == 16'h37c0;
   endproperty
   a_home_req: assert property (p_home_req)
      else $error("no save after homing");
   property p_ack_hold;
      nvm_wr_req && !nvm_wr_ack
         |=> nvm_wr_req && $stable(nvm_wr_addr) && $stable(nvm_wr_data);
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("memory request dropped");
   property p_high_low;
      nvm_wr_req && nvm_wr_ack && nvm_wr_addr == 16'h37c0
         |=> nvm_wr_req && nvm_wr_addr == 16'h37c1;
   endproperty
   a_high_low: assert property (p_high_low)
      else $error("low word not after high");
   property p_addr_legal;
      nvm_wr_req |-> nvm_wr_addr inside {16'h37c0, 16'h37c1};
   endproperty
   a_addr_legal: assert property (p_addr_legal)
      else $error("save of other address");
   property p_incr;
      !offset_applied |-> act_pos == $past(pos_raw);
   endproperty
   a_incr: assert property (p_incr)
      else $error("offset used in incremental");
   property p_home_zero;
      homing_done && offset_applied && !scale_sel && !boot_valid
         ##1 (pos_raw == $past(home_raw) && !homing_done && !boot_valid)
         |=> act_pos == 64'h0;
   endproperty
   a_home_zero: assert property (p_home_zero)
      else $error("position not zero at home");
   property p_manual;
      reg_wr && reg_addr inside {16'h37c0, 16'h37c1} && !homing_done
         && !boot_valid ##1 ($stable(pos_raw) && !homing_done && !boot_valid)
         |=> $stable(act_pos);
   endproperty
   a_manual: assert property (p_manual)
      else $error("manual write applied at once");
endmodule : absolute_home_offset_store_sva
bind absolute_home_offset_store absolute_home_offset_store_sva
   absolute_home_offset_store_sva_inst (.clk_sys, .rst, .reg_wr, .reg_rd,
   .reg_addr, .reg_rdata, .homing_done, .boot_valid, .scale_sel, .home_raw,
   .pos_raw, .nvm_wr_req, .nvm_wr_addr, .nvm_wr_data, .nvm_wr_ack, .act_pos,
   .offset_applied);

// ### absolute_home_offset_store_tb_top.sv
// self-checking bench for the home offset store
`timescale 1ns/1ns
module absolute_home_offset_store_tb_top;
   import home_offset_pkg::*;
   logic        clk_sys, rst, reg_wr, reg_rd, homing_done, scale_sel;
   logic        boot_valid, nvm_wr_req, nvm_wr_ack, offset_applied, save_busy;
   logic [15:0] reg_addr, nvm_wr_addr;
   logic [31:0] reg_wdata, reg_rdata, boot_high, boot_low, nvm_wr_data;
   logic [23:0] scale_upper, scale_lower;
   logic [63:0] home_raw, pos_raw, act_pos, mem, act_m, st_m, nv_m, pos_m;
   logic [7:0]  mode_m;
   logic [3:0]  lat;
   int          wr_cnt, errors, tests_run, cnt, seed;
   absolute_home_offset_store absolute_home_offset_store_inst (.clk_sys,
      .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .homing_done,
      .scale_sel, .home_raw, .scale_upper, .scale_lower, .pos_raw, .boot_valid,
      .boot_high, .boot_low, .nvm_wr_req, .nvm_wr_addr, .nvm_wr_data,
      .nvm_wr_ack, .act_pos, .offset_applied, .save_busy);
   offset_nvm_model offset_nvm_model_inst (.clk_sys, .rst, .nvm_wr_req,
      .nvm_wr_addr, .nvm_wr_data, .lat, .nvm_wr_ack, .mem, .wr_cnt);
   // ----------------
   // tasks
   // ----------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(64'(reg_rdata), 64'(v));
   endtask : rd
   task automatic wait_save(input int n);
      cnt += n;
      repeat (20) @(posedge clk_sys);
      for (int i = 0; i < 200 && wr_cnt != cnt; i++) @(posedge clk_sys);
      chk(64'(wr_cnt), 64'(cnt));
      chk(64'(save_busy), 64'h0);
   endtask : wait_save
   task automatic home(input logic sel, input logic [3:0] l);
      logic [63:0] h;
      logic [23:0] u, w;
      h = {$random(seed), $random(seed)};
      u = 24'($random(seed));
      w = 24'($random(seed));
      @(posedge clk_sys);
      lat         <= l;
      scale_sel   <= sel;
      home_raw    <= h;
      scale_upper <= u;
      scale_lower <= w;
      homing_done <= 1'b1;
      @(posedge clk_sys);
      homing_done <= 1'b0;
      if (sel) h = {{16{u[23]}}, u, w};
      pos_raw <= h;
      pos_m = h;
      if (mode_m != ENC_MODE_INCR) begin
         {act_m, st_m, nv_m} = {h, h, h};
      end
      wait_save((mode_m != ENC_MODE_INCR) ? 2 : 0);
   endtask : home
   task automatic boot;
      @(posedge clk_sys);
      boot_high  <= st_m[63:32];
      boot_low   <= st_m[31:0];
      boot_valid <= 1'b1;
      @(posedge clk_sys);
      boot_valid <= 1'b0;
      act_m = st_m;
   endtask : boot
   task automatic chk_all;
      rd(OFS_HIGH_ADDR, st_m[63:32]);
      rd(OFS_LOW_ADDR, st_m[31:0]);
      chk(mem, nv_m);
      repeat (3) @(posedge clk_sys);
      #1 chk(act_pos, pos_m - ((mode_m == ENC_MODE_INCR) ? 64'h0 : act_m));
   endtask : chk_all
   task automatic final_report;
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // ----------------
   // sequence
   // ----------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      final_report;
   end
   initial begin
      seed = 32'h679c6814;
      {reg_wr, reg_rd, homing_done, scale_sel, boot_valid, lat} = '0;
      {reg_addr, reg_wdata, home_raw, scale_upper, scale_lower} = '0;
      {pos_raw, boot_high, boot_low, act_m, st_m, nv_m, pos_m, mode_m} = '0;
      {errors, tests_run, cnt} = '0;
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(ENC_MODE_ADDR, 32'h0);
      rd(16'h1234, RDATA_UNMAPPED);
      chk_all;
      home(1'b0, 4'h0);
      chk_all;
      home(1'b1, 4'h6);
      chk_all;
      st_m = {$random(seed), $random(seed)};
      wr(OFS_HIGH_ADDR, st_m[63:32]);
      wr(OFS_LOW_ADDR, st_m[31:0]);
      rd(STATUS_ADDR, (32'h1 << ST_APPLIED_BIT) | (32'h1 << ST_NONZERO_BIT)
         | (32'h1 << ST_PENDING_BIT) | (32'h1 << ST_HOMED_BIT)
         | (32'h1 << ST_SCALE_BIT));
      chk_all;
      boot;
      chk_all;
      wr(OFS_HIGH_ADDR, 32'h0);
      wr(OFS_LOW_ADDR, 32'h0);
      wr(CTRL_ADDR, 32'h1 << CTRL_SAVE_BIT);
      {st_m, nv_m} = '0;
      wait_save(2);
      boot;
      chk_all;
      wr(ENC_MODE_ADDR, {24'h0, ENC_MODE_INCR});
      mode_m = ENC_MODE_INCR;
      rd(ENC_MODE_ADDR, {24'h0, ENC_MODE_INCR});
      home(1'b0, 4'h0);
      chk_all;
      chk(64'(offset_applied), 64'h0);
      final_report;
   end
endmodule : absolute_home_offset_store_tb_top

// ### home_offset_pkg.sv
// package with the map, fields and codes of the home offset store
package home_offset_pkg;

   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 32;
   localparam int          POS_W           = 64;
   localparam int          SCALE_PART_W    = 24;

   // register map
   localparam logic [15:0] OFS_HIGH_ADDR   = 16'h37c0;
   localparam logic [15:0] OFS_LOW_ADDR    = 16'h37c1;
   localparam logic [15:0] CTRL_ADDR       = 16'h37c2;
   localparam logic [15:0] STATUS_ADDR     = 16'h37c3;
   localparam logic [15:0] ENC_MODE_ADDR   = 16'h3015;

   // reset values
   localparam logic [31:0] OFS_RESET       = 32'h0000_0000;
   localparam logic [7:0]  ENC_MODE_RESET  = 8'h00;
   localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;

   // encoder mode value that selects incremental operation
   localparam logic [7:0]  ENC_MODE_INCR   = 8'h01;
   localparam int          ENC_MODE_W      = 8;

   // control register fields (write one to act)
   localparam int          CTRL_SAVE_BIT   = 0;

   // status register fields
   localparam int          ST_APPLIED_BIT  = 0;
   localparam int          ST_BUSY_BIT     = 1;
   localparam int          ST_NONZERO_BIT  = 2;
   localparam int          ST_PENDING_BIT  = 3;
   localparam int          ST_HOMED_BIT    = 4;
   localparam int          ST_SCALE_BIT    = 5;

   typedef enum logic [1:0] {
      SAVE_IDLE,
      SAVE_HIGH,
      SAVE_LOW
   } save_state_e;

endpackage : home_offset_pkg

// ### offset_nvm_model.sv
// memory model that accepts offset word writes
`timescale 1ns/1ns
module offset_nvm_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        nvm_wr_req,
   input  wire logic [15:0] nvm_wr_addr,
   input  wire logic [31:0] nvm_wr_data,
   input  wire logic [3:0]  lat,
   output      logic        nvm_wr_ack,
   output      logic [63:0] mem,
   output      int          wr_cnt
);
   logic [3:0] wait_q;
   // ack lat+1 cycles after each request; one pulse per word
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nvm_wr_ack <= 1'b0;
         wait_q     <= 4'h0;
         mem        <= 64'h0;
         wr_cnt     <= 0;
      end else begin
         nvm_wr_ack <= 1'b0;
         if (nvm_wr_req && nvm_wr_ack) begin
            wait_q <= 4'h0;
            wr_cnt <= wr_cnt + 1;
            if (nvm_wr_addr == 16'h37c0) begin
               mem[63:32] <= nvm_wr_data;
            end else begin
               mem[31:0] <= nvm_wr_data;
            end
         end else if (nvm_wr_req) begin
            if (wait_q >= lat) begin
               nvm_wr_ack <= 1'b1;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule : offset_nvm_model

// ### offset_nvm_writer.sv
// writes the two offset words to nonvolatile memory, nothing else
`timescale 1ns/1ns
module offset_nvm_writer
   import home_offset_pkg::*;
(
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   offset_save_if.writer                       save,
   output      logic                           nvm_wr_req,
   output      logic [home_offset_pkg::ADDR_W-1:0] nvm_wr_addr,
   output      logic [home_offset_pkg::DATA_W-1:0] nvm_wr_data,
   input  wire logic                           nvm_wr_ack
);
   import home_offset_pkg::*;

   save_state_e state_q, state_d;
   logic [31:0] high_q, high_d;
   logic [31:0] low_q, low_d;
   logic        again_q, again_d;

   always_comb begin
      state_d = state_q;
      high_d  = high_q;
      low_d   = low_q;
      again_d = again_q;
      if (save.start && state_q != SAVE_IDLE) begin
         // request during a save: remember it, keep the word on the port stable
         again_d = 1'b1;
      end
      case (state_q)
         SAVE_IDLE: begin
            if (save.start) begin
               high_d  = save.high_word;
               low_d   = save.low_word;
               state_d = SAVE_HIGH;
            end
         end
         SAVE_HIGH: begin
            if (nvm_wr_ack) begin
               state_d = SAVE_LOW;
            end
         end
         SAVE_LOW: begin
            if (nvm_wr_ack) begin
               if (again_q || save.start) begin
                  // restart picks up the words as they stand now
                  again_d = 1'b0;
                  high_d  = save.high_word;
                  low_d   = save.low_word;
                  state_d = SAVE_HIGH;
               end else begin
                  state_d = SAVE_IDLE;
               end
            end
         end
         default: state_d = SAVE_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= SAVE_IDLE;
         high_q  <= OFS_RESET;
         low_q   <= OFS_RESET;
         again_q <= 1'b0;
      end else begin
         state_q <= state_d;
         high_q  <= high_d;
         low_q   <= low_d;
         again_q <= again_d;
      end
   end

   // only the two offset words ever reach the memory R5
   assign nvm_wr_req  = (state_q != SAVE_IDLE);
   assign nvm_wr_addr = (state_q == SAVE_LOW) ? OFS_LOW_ADDR : OFS_HIGH_ADDR;
   assign nvm_wr_data = (state_q == SAVE_LOW) ? low_q : high_q;
   assign save.busy   = (state_q != SAVE_IDLE);

endmodule : offset_nvm_writer

// ### offset_save_if.sv
// interface carrying a save request from the store to the writer
`timescale 1ns/1ns
interface offset_save_if;
   logic        start;
   logic        busy;
   logic [31:0] high_word;
   logic [31:0] low_word;

   modport store (output start, output high_word, output low_word, input busy);
   modport writer (input start, input high_word, input low_word, output busy);
endinterface : offset_save_if
